// File: verilog/dfd_consts.svh
// constants for the directional fault decision block
// Operation
// - rotate phase reference by phase rotation setting
// - phase reference is other two phases' voltage
// - forward within plus/minus 86 degrees
// - reverse in mirrored sector opposite reference
// - undefined between forward and reverse sectors
// - leave at 86, enter at 84 degrees
// - ground reference is displacement or 3V0 voltage
// - ground uses its own rotation setting
// - ground forward uses inverted 3I0 or IN
// - negative-sequence mode references rotated 3V2
// - negative-sequence forward uses inverted 3I2
// - forward fault blocks busbar neighbours' stages
// - forward message after threshold and direction
// - reverse fault blocks opposite end stages
// - one separate path per transfer direction
// - broken closed loop signalled after delay
// - time-graded stage works independently as backup
// - weak polarizing voltage leaves ground undefined
`ifndef DFD_CONSTS_SVH
`define DFD_CONSTS_SVH
`define DFD_ANG_W 10
`define DFD_FWD_LEAVE 10'h056
`define DFD_FWD_ENTER 10'h054
`define DFD_REV_LEAVE 10'h05e
`define DFD_REV_ENTER 10'h060
`define DFD_HALF_TURN 12'h0b4
`define DFD_FULL_TURN 12'h168
`define DFD_ANG_MAX 12'h0b3
`define DFD_CLK_PERIOD_NS 10
`define DFD_LOOP_FAIL_MS 1000
`define DFD_LOOP_FAIL_CYCLES (`DFD_LOOP_FAIL_MS * 1000000 / `DFD_CLK_PERIOD_NS)
`endif

// File: verilog/dfd_pkg.sv
// types for the directional fault decision block
`default_nettype none
package dfd_pkg;
   // codes: undefined -> forward flips one bit, undefined -> reverse flips two
   typedef enum logic [1:0] {
      DFD_UNDEF = 2'h0,
      DFD_FWD = 2'h1,
      DFD_REV = 2'h3
   } dfd_dir_t;
   typedef enum logic {
      DFD_ZERO_SEQ = 1'h0,
      DFD_NEG_SEQ = 1'h1
   } dfd_gnd_mode_t;
endpackage
`default_nettype wire

// File: verilog/dfd_top.sv
// directional decision, hysteresis and pilot-wire interlock
`timescale 1ns/1ns
`default_nettype none
`include "dfd_consts.svh"
module dfd_top
   import dfd_pkg::*;
#(
   parameter int LOOP_FAIL_CYCLES = `DFD_LOOP_FAIL_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // current angles, degrees -180..179
   input wire logic signed [9:0] iaAngle,
   input wire logic signed [9:0] ibAngle,
   input wire logic signed [9:0] icAngle,
   input wire logic signed [9:0] inAngle,
   input wire logic signed [9:0] i0Angle,
   input wire logic signed [9:0] i2Angle,
   // voltage angles, degrees -180..179
   input wire logic signed [9:0] vbcAngle,
   input wire logic signed [9:0] vcaAngle,
   input wire logic signed [9:0] vabAngle,
   input wire logic signed [9:0] vnAngle,
   input wire logic signed [9:0] v0Angle,
   input wire logic signed [9:0] v2Angle,
   // settings
   input wire logic signed [9:0] phaseRot,
   input wire logic signed [9:0] gndRot,
   input wire dfd_gnd_mode_t gndMode,
   input wire logic vnConnected,
   input wire logic inMeasured,
   input wire logic closedCircuit,
   input wire logic selInverseStage,
   input wire dfd_dir_t backupDirSet,
   // pickups and magnitude checks
   input wire logic [2:0] phasePickup,
   input wire logic gndPickup,
   input wire logic gndPolOk,
   input wire logic lowStageOver,
   // pilot-wire receive pins
   input wire logic fwdLineIn,
   input wire logic revLineIn,
   // element directions
   output logic [1:0] dirA,
   output logic [1:0] dirB,
   output logic [1:0] dirC,
   output logic [1:0] dirGnd,
   output logic gndTripPermit,
   // direction messages
   output logic fwdMsg,
   output logic revMsg,
   // pilot-wire transmit pins
   output logic fwdLineOut,
   output logic revLineOut,
   // blocking of local non-directional stages
   output logic blockNondirLowStage,
   output logic blockNondirectionalInverseStage,
   // loop supervision
   output logic fwdLoopBroken,
   output logic revLoopBroken,
   // time-graded stage
   output logic backupDirMatch
);

   // wrap any sum in -900..899 into -180..179
   function automatic logic signed [9:0] wrap_angle(input logic signed [11:0] x);
      logic signed [11:0] t;
      t = x;
      if (t > $signed(`DFD_ANG_MAX)) begin
         t = t - $signed(`DFD_FULL_TURN);
      end
      if (t > $signed(`DFD_ANG_MAX)) begin
         t = t - $signed(`DFD_FULL_TURN);
      end
      if (t < -$signed(`DFD_HALF_TURN)) begin
         t = t + $signed(`DFD_FULL_TURN);
      end
      if (t < -$signed(`DFD_HALF_TURN)) begin
         t = t + $signed(`DFD_FULL_TURN);
      end
      return t[9:0];
   endfunction

   // current minus rotated reference, wrapped
   function automatic logic signed [9:0] angle_diff(
      input logic signed [9:0] cur,
      input logic signed [9:0] ref_ang,
      input logic signed [9:0] rot
   );
      logic signed [11:0] s;
      s = 12'(cur) - 12'(ref_ang) - 12'(rot);
      return wrap_angle(s);
   endfunction

   function automatic logic [9:0] abs_angle(input logic signed [9:0] a);
      logic [9:0] m;
      m = a[9] ? 10'(-a) : 10'(a);
      return m;
   endfunction

   // sector decision with hysteresis on entry
   function automatic dfd_dir_t next_dir(
      input dfd_dir_t cur,
      input logic signed [9:0] d,
      input logic valid
   );
      logic [9:0] m;
      dfd_dir_t n;
      m = abs_angle(d);
      n = DFD_UNDEF;
      case (cur)
         DFD_FWD: begin
            if (m <= `DFD_FWD_LEAVE) begin
               n = DFD_FWD;
            end
         end
         DFD_REV: begin
            if (m >= `DFD_REV_LEAVE) begin
               n = DFD_REV;
            end
         end
         DFD_UNDEF: begin
            if (m <= `DFD_FWD_ENTER) begin
               n = DFD_FWD;
            end else if (m >= `DFD_REV_ENTER) begin
               n = DFD_REV;
            end
         end
         default: begin
            n = DFD_UNDEF;
         end
      endcase
      // no pickup or weak polarization: nothing to decide
      if (!valid) begin
         n = DFD_UNDEF;
      end
      return n;
   endfunction

   // ground source selection
   wire logic signed [9:0] gndRefZero;
   wire logic signed [9:0] gndCurZero;
   wire logic signed [9:0] gndCurNeg;
   wire logic signed [9:0] gndRefSel;
   wire logic signed [9:0] gndCurSel;
   wire logic gndValid;
   assign gndRefZero = vnConnected ? vnAngle : v0Angle;
   // inverting a phasor is a half turn
   assign gndCurZero = inMeasured ? inAngle
      : wrap_angle(12'(i0Angle) + $signed(`DFD_HALF_TURN));
   assign gndCurNeg = wrap_angle(12'(i2Angle) + $signed(`DFD_HALF_TURN));
   assign gndRefSel = (gndMode == DFD_NEG_SEQ) ? v2Angle : gndRefZero;
   assign gndCurSel = (gndMode == DFD_NEG_SEQ) ? gndCurNeg : gndCurZero;
   assign gndValid = gndPickup && gndPolOk;

   // differences, one per element
   wire logic signed [9:0] diffA;
   wire logic signed [9:0] diffB;
   wire logic signed [9:0] diffC;
   wire logic signed [9:0] diffGnd;
   assign diffA = angle_diff(iaAngle, vbcAngle, phaseRot);
   assign diffB = angle_diff(ibAngle, vcaAngle, phaseRot);
   assign diffC = angle_diff(icAngle, vabAngle, phaseRot);
   assign diffGnd = angle_diff(gndCurSel, gndRefSel, gndRot);

   // one pipeline stage keeps the long wrap chain off the state path
   logic signed [9:0] diffAq;
   logic signed [9:0] diffBq;
   logic signed [9:0] diffCq;
   logic signed [9:0] diffGq;
   logic [3:0] validQ;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         diffAq <= 10'h000;
         diffBq <= 10'h000;
         diffCq <= 10'h000;
         diffGq <= 10'h000;
         validQ <= 4'h0;
      end else begin
         diffAq <= diffA;
         diffBq <= diffB;
         diffCq <= diffC;
         diffGq <= diffGnd;
         validQ <= {gndValid, phasePickup};
      end
   end

   // direction state per element
   dfd_dir_t stA;
   dfd_dir_t stB;
   dfd_dir_t stC;
   dfd_dir_t stG;
   wire dfd_dir_t next_stA;
   wire dfd_dir_t next_stB;
   wire dfd_dir_t next_stC;
   wire dfd_dir_t next_stG;
   assign next_stA = next_dir(stA, diffAq, validQ[0]);
   assign next_stB = next_dir(stB, diffBq, validQ[1]);
   assign next_stC = next_dir(stC, diffCq, validQ[2]);
   assign next_stG = next_dir(stG, diffGq, validQ[3]);
   always_ff @(posedge clock) begin
      if (!nrst) begin
         stA <= DFD_UNDEF;
         stB <= DFD_UNDEF;
         stC <= DFD_UNDEF;
         stG <= DFD_UNDEF;
      end else begin
         stA <= next_stA;
         stB <= next_stB;
         stC <= next_stC;
         stG <= next_stG;
      end
   end

   // any element seeing a direction
   wire logic anyFwd;
   wire logic anyRev;
   wire logic next_fwdMsg;
   wire logic next_revMsg;
   wire logic next_backup;
   assign anyFwd = (stA == DFD_FWD) || (stB == DFD_FWD) || (stC == DFD_FWD) || (stG == DFD_FWD);
   assign anyRev = (stA == DFD_REV) || (stB == DFD_REV) || (stC == DFD_REV) || (stG == DFD_REV);
   assign next_fwdMsg = lowStageOver && anyFwd;
   assign next_revMsg = lowStageOver && anyRev;
   // backup ignores the interlock entirely
   assign next_backup = (backupDirSet != DFD_UNDEF) && ((stA == backupDirSet)
      || (stB == backupDirSet) || (stC == backupDirSet) || (stG == backupDirSet));

   // receive paths: three flops, accept when the last two agree
   logic [2:0] fwdSync;
   logic [2:0] revSync;
   logic fwdLevel;
   logic revLevel;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         fwdSync <= 3'h0;
         revSync <= 3'h0;
      end else begin
         fwdSync <= {fwdSync[1:0], fwdLineIn};
         revSync <= {revSync[1:0], revLineIn};
      end
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         fwdLevel <= 1'h0;
         revLevel <= 1'h0;
      end else begin
         if (fwdSync[1] == fwdSync[2]) begin
            fwdLevel <= fwdSync[2];
         end
         if (revSync[1] == revSync[2]) begin
            revLevel <= revSync[2];
         end
      end
   end

   // closed circuit: idle line carries current, a message opens it
   wire logic fwdRx;
   wire logic revRx;
   wire logic rxBlock;
   assign fwdRx = closedCircuit ? !fwdLevel : fwdLevel;
   assign revRx = closedCircuit ? !revLevel : revLevel;
   assign rxBlock = fwdRx || revRx;

   // loop supervision: a line held open too long is a broken loop
   logic [31:0] fwdOpenCnt;
   logic [31:0] revOpenCnt;
   wire logic fwdOpenDone;
   wire logic revOpenDone;
   assign fwdOpenDone = fwdOpenCnt >= 32'(LOOP_FAIL_CYCLES);
   assign revOpenDone = revOpenCnt >= 32'(LOOP_FAIL_CYCLES);
   always_ff @(posedge clock) begin
      if (!nrst) begin
         fwdOpenCnt <= 32'h0000_0000;
      end else if (!closedCircuit || fwdLevel) begin
         fwdOpenCnt <= 32'h0000_0000;
      end else if (!fwdOpenDone) begin
         fwdOpenCnt <= fwdOpenCnt + 32'h0000_0001;
      end
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         revOpenCnt <= 32'h0000_0000;
      end else if (!closedCircuit || revLevel) begin
         revOpenCnt <= 32'h0000_0000;
      end else if (!revOpenDone) begin
         revOpenCnt <= revOpenCnt + 32'h0000_0001;
      end
   end

   // registered outputs
   always_ff @(posedge clock) begin
      if (!nrst) begin
         dirA <= DFD_UNDEF;
         dirB <= DFD_UNDEF;
         dirC <= DFD_UNDEF;
         dirGnd <= DFD_UNDEF;
         gndTripPermit <= 1'h0;
         fwdMsg <= 1'h0;
         revMsg <= 1'h0;
         backupDirMatch <= 1'h0;
      end else begin
         dirA <= stA;
         dirB <= stB;
         dirC <= stC;
         dirGnd <= stG;
         gndTripPermit <= (stG != DFD_UNDEF);
         fwdMsg <= next_fwdMsg;
         revMsg <= next_revMsg;
         backupDirMatch <= next_backup;
      end
   end

   // each direction owns its own wire pair
   always_ff @(posedge clock) begin
      if (!nrst) begin
         fwdLineOut <= 1'h0;
         revLineOut <= 1'h0;
      end else begin
         fwdLineOut <= closedCircuit ? !next_fwdMsg : next_fwdMsg;
         revLineOut <= closedCircuit ? !next_revMsg : next_revMsg;
      end
   end

   // a broken loop keeps blocking: fail safe, backup still trips
   always_ff @(posedge clock) begin
      if (!nrst) begin
         blockNondirLowStage <= 1'h0;
         blockNondirectionalInverseStage <= 1'h0;
         fwdLoopBroken <= 1'h0;
         revLoopBroken <= 1'h0;
      end else begin
         blockNondirLowStage <= rxBlock && !selInverseStage;
         blockNondirectionalInverseStage <= rxBlock && selInverseStage;
         fwdLoopBroken <= fwdOpenDone;
         revLoopBroken <= revOpenDone;
      end
   end

endmodule
`default_nettype wire

// File: verif/dfd_top_chk.sv
// concurrent checks on the directional fault decision ports
`timescale 1ns/1ns
`default_nettype none
module dfd_chk
   import dfd_pkg::*;
#(
   parameter int LOOP_FAIL_CYCLES = 20
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // watched inputs
   input wire logic [2:0] phasePickup,
   input wire logic gndPolOk,
   input wire logic lowStageOver,
   input wire logic closedCircuit,
   input wire logic selInverseStage,
   input wire logic fwdLineIn,
   // watched outputs
   input wire logic [1:0] dirA,
   input wire logic [1:0] dirB,
   input wire logic [1:0] dirC,
   input wire logic [1:0] dirGnd,
   input wire logic gndTripPermit,
   input wire logic fwdMsg,
   input wire logic revMsg,
   input wire logic fwdLineOut,
   input wire logic revLineOut,
   input wire logic blockNondirLowStage,
   input wire logic fwdLoopBroken
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   int lowRun;
   // raw pin low run; the sync stages only lengthen it, so a lower bound is safe
   always_ff @(posedge clock) begin
      lowRun <= (!nrst || fwdLineIn) ? 0 : lowRun + 1;
   end
   AST_PHASE_UNDEF: assert property (!phasePickup[0] [*3] |=> dirA == 2'h0)
      else $error("phase direction set without pickup");
   AST_GND_WEAK: assert property (!gndPolOk [*3] |=> dirGnd == 2'h0 && !gndTripPermit)
      else $error("ground direction set with weak polarizing voltage");
   AST_NO_SWAP: assert property (dirA == 2'h1 |=> dirA != 2'h3)
      else $error("forward turned to reverse without undefined");
   AST_FWD_MSG_DIR: assert property (fwdMsg |-> dirA == 2'h1 || dirB == 2'h1 || dirC == 2'h1 || dirGnd == 2'h1)
      else $error("forward message without forward element");
   AST_FWD_MSG_OVER: assert property (fwdMsg |-> $past(lowStageOver))
      else $error("forward message below threshold");
   AST_LINE_POL: assert property ($past(nrst) && closedCircuit && $past(closedCircuit)
      |-> fwdLineOut == !fwdMsg && revLineOut == !revMsg)
      else $error("closed circuit line level wrong");
   AST_RX_BLOCK: assert property ((!closedCircuit && !selInverseStage && fwdLineIn) [*6]
      |=> blockNondirLowStage)
      else $error("received message did not block");
   AST_LOOP_DELAY: assert property ($rose(fwdLoopBroken) |-> lowRun >= LOOP_FAIL_CYCLES)
      else $error("loop alarm too early");
   // alarm trails the counter by one flop, so look two edges back
   AST_LOOP_CLOSED: assert property (fwdLoopBroken |-> $past(closedCircuit, 2))
      else $error("loop alarm in open circuit");
endmodule
bind dfd_top dfd_chk #(.LOOP_FAIL_CYCLES(LOOP_FAIL_CYCLES)) chk (.*);
`default_nettype wire

// File: verif/dfd_partner.sv
// neighbouring relay at the far end of the pilot wires
`timescale 1ns/1ns
`default_nettype none
module dfd_partner (
   // clock
   input wire logic clock,
   // far relay controls
   input wire logic closedCircuit,
   input wire logic sendFwd,
   input wire logic sendRev,
   input wire logic loopOpen,
   // pilot wires from the block
   input wire logic fwdLineOut,
   input wire logic revLineOut,
   // pilot wires to the block
   output var logic fwdLineIn = 1'h0,
   output var logic revLineIn = 1'h0,
   // messages as the far relay reads them
   output logic gotFwd,
   output logic gotRev
);
   // an opened loop reads low whatever the sender wants
   // lines move on the rising edge so the bench's falling-edge settings are already stable
   always @(posedge clock) begin
      fwdLineIn <= !loopOpen && (sendFwd ^ closedCircuit);
      revLineIn <= !loopOpen && (sendRev ^ closedCircuit);
   end
   assign gotFwd = fwdLineOut ^ closedCircuit;
   assign gotRev = revLineOut ^ closedCircuit;
endmodule
`default_nettype wire

// File: verif/tb_directional_fault_decision.sv
// self-checking bench for the directional fault decision block
`timescale 1ns/1ns
`default_nettype none
`define CK(g, e) begin samplesChecked++; if ((g) !== (e)) begin nErrors++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb_directional_fault_decision;
   import dfd_pkg::*;
   logic clock = 1'h0;
   logic nrst = 1'h0;
   logic signed [9:0] iaAngle, ibAngle, icAngle, inAngle, i0Angle, i2Angle, phaseRot, gndRot;
   logic signed [9:0] vbcAngle, vcaAngle, vabAngle, vnAngle, v0Angle, v2Angle;
   dfd_gnd_mode_t gndMode;
   dfd_dir_t backupDirSet;
   logic vnConnected, inMeasured, closedCircuit, selInverseStage, gndPickup, gndPolOk, lowStageOver;
   logic [2:0] phasePickup;
   logic fwdLineIn, revLineIn, sendFwd, sendRev, loopOpen, gotFwd, gotRev;
   logic [1:0] dirA, dirB, dirC, dirGnd;
   logic gndTripPermit, fwdMsg, revMsg, fwdLineOut, revLineOut, blockNondirLowStage;
   logic blockNondirectionalInverseStage, fwdLoopBroken, revLoopBroken, backupDirMatch;
   int nErrors = 0;
   int samplesChecked = 0;
   int cycles = 0;
   logic signed [9:0] rowCur [9] = '{10'sh054, 10'sh055, -10'sh054, 10'sh060, 10'sh05f, -10'sh0b4,
      10'sh02d, 10'sh05a, -10'sh0aa};
   logic signed [9:0] rowRef [9] = '{0, 0, 0, 0, 0, 0, 0, 0, 10'sh0aa};
   logic signed [9:0] rowRot [9] = '{0, 0, 0, 0, 0, 0, 10'sh02d, -10'sh02d, 0};
   logic [1:0] rowExp [9] = '{1, 0, 1, 3, 0, 3, 1, 3, 1};
   logic signed [9:0] hsCur [9] = '{10'sh056, 10'sh057, 10'sh055, 10'sh054, -10'sh0b4, 10'sh05e,
      10'sh05d, 10'sh05f, 10'sh060};
   logic [1:0] hsExp [9] = '{1, 0, 0, 1, 3, 3, 0, 0, 3};
   logic [2:0] gRow [5] = '{3'h3, 3'h2, 3'h1, 3'h0, 3'h7};
   logic [1:0] gExp [5] = '{1, 3, 3, 1, 3};

   dfd_top #(.LOOP_FAIL_CYCLES(20)) uut (.*);
   dfd_partner far (.*);

   initial begin
      forever #5 clock = ~clock;
   end

   task automatic stopTest();
      $display("errors %0d checks %0d", nErrors, samplesChecked);
      if (nErrors == 0 && samplesChecked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // about 320 cycles are needed; the margin covers slow settling
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         nErrors++;
         stopTest();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic ang(input logic signed [9:0] c, input logic signed [9:0] r, input logic signed [9:0] rot);
      {iaAngle, ibAngle, icAngle, inAngle} = {4{c}};
      {vbcAngle, vcaAngle, vabAngle, vnAngle} = {4{r}};
      phaseRot = rot;
      gndRot = rot;
      cyc(6);
   endtask

   initial begin
      {iaAngle, ibAngle, icAngle, inAngle, i0Angle, i2Angle, phaseRot, gndRot} = '0;
      {vbcAngle, vcaAngle, vabAngle, vnAngle, v0Angle, v2Angle} = '0;
      gndMode = DFD_ZERO_SEQ;
      backupDirSet = DFD_UNDEF;
      {vnConnected, inMeasured, closedCircuit, selInverseStage, gndPickup} = 5'h1d;
      {gndPolOk, lowStageOver, sendFwd, sendRev, loopOpen} = 5'h10;
      phasePickup = 3'h7;
      cyc(20);
      `CK(fwdLineOut, 1'h0)
      `CK(dirA, 2'h0)
      nrst = 1'h1;
      closedCircuit = 1'h0;
      cyc(4);
      for (int i = 0; i < 9; i++) begin
         phasePickup = 3'h0;
         gndPickup = 1'h0;
         cyc(3);
         phasePickup = 3'h7;
         gndPickup = 1'h1;
         ang(rowCur[i], rowRef[i], rowRot[i]);
         `CK(dirA, rowExp[i])
         `CK(dirB, rowExp[i])
         `CK(dirC, rowExp[i])
         `CK(dirGnd, rowExp[i])
      end
      ang(0, 0, 0);
      vcaAngle = -10'sh0b4;
      vabAngle = 10'sh05a;
      cyc(6);
      `CK(dirA, 2'h1)
      `CK(dirB, 2'h3)
      `CK(dirC, 2'h0)
      ang(10'sh050, 0, 0);
      for (int i = 0; i < 9; i++) begin
         iaAngle = hsCur[i];
         cyc(6);
         `CK(dirA, hsExp[i])
      end
      ang(0, 0, 0);
      v0Angle = -10'sh0b4;
      for (int i = 0; i < 5; i++) begin
         gndMode = dfd_gnd_mode_t'(gRow[i][2]);
         {vnConnected, inMeasured} = gRow[i][1:0];
         cyc(6);
         `CK(dirGnd, gExp[i])
      end
      gndMode = DFD_ZERO_SEQ;
      gndRot = -10'sh0b4;
      cyc(6);
      `CK(dirGnd, 2'h3)
      `CK(dirA, 2'h1)
      `CK(gndTripPermit, 1'h1)
      gndPolOk = 1'h0;
      cyc(6);
      `CK(dirGnd, 2'h0)
      `CK(gndTripPermit, 1'h0)
      gndPolOk = 1'h1;
      backupDirSet = DFD_FWD;
      ang(0, 0, 0);
      `CK(backupDirMatch, 1'h1)
      lowStageOver = 1'h1;
      cyc(6);
      `CK(fwdMsg, 1'h1)
      `CK(revMsg, 1'h0)
      `CK(gotFwd, 1'h1)
      lowStageOver = 1'h0;
      cyc(6);
      `CK(fwdMsg, 1'h0)
      lowStageOver = 1'h1;
      ang(-10'sh0b4, 0, 0);
      `CK(revMsg, 1'h1)
      `CK(gotRev, 1'h1)
      `CK(backupDirMatch, 1'h0)
      closedCircuit = 1'h1;
      cyc(6);
      `CK(revLineOut, 1'h0)
      `CK(fwdLineOut, 1'h1)
      {closedCircuit, lowStageOver, sendFwd} = 3'h1;
      cyc(8);
      `CK(blockNondirLowStage, 1'h1)
      `CK(blockNondirectionalInverseStage, 1'h0)
      {selInverseStage, sendFwd, sendRev} = 3'h5;
      cyc(8);
      `CK(blockNondirectionalInverseStage, 1'h1)
      `CK(blockNondirLowStage, 1'h0)
      {sendRev, closedCircuit, loopOpen} = 3'h3;
      cyc(10);
      `CK(fwdLoopBroken, 1'h0)
      cyc(20);
      `CK(fwdLoopBroken, 1'h1)
      `CK(revLoopBroken, 1'h1)
      loopOpen = 1'h0;
      cyc(8);
      `CK(fwdLoopBroken, 1'h0)
      // mid-run reset must clear the registered outputs
      nrst = 1'h0;
      cyc(2);
      `CK(dirA, 2'h0)
      `CK(fwdMsg, 1'h0)
      `CK(fwdLineOut, 1'h0)
      nrst = 1'h1;
      cyc(4);
      stopTest();
   end
endmodule
`default_nettype wire
